/* dv/dbp_sync_src.sv */
// Behavioural clock source that drives the timing input of the PWM block.
// Assumes the receiver samples on CLK; the level changes only at the falling edge.
`timescale 1ns/1ps
module dbp_sync_src #(
   parameter int LOW_CYC = 2
) (
   input  wire logic CLK,
   input  wire logic run,
   output logic      sync_out
);
   int cnt;

   initial begin
      sync_out = 1'b0;
      cnt = 0;
   end

   // A 10 MHz clock cannot make the 6-8 MHz band, so the rate is scaled down to the clock
   always @(negedge CLK) begin
      if (!run) begin
         sync_out <= 1'b0;
         cnt <= 0;
      end else begin
         sync_out <= (cnt == 0);
         cnt <= (cnt == LOW_CYC) ? 0 : cnt + 1;
      end
   end
endmodule : dbp_sync_src

/* dv/tb_dbp_top.sv */
// Self-checking bench for the dual-channel PWM block.
// Assumes a short soft-start parameter so that a hiccup lasts 80 clocks.
`timescale 1ns/1ps
module tb_dbp_top;
   import dbp_pkg::*;
   localparam int SS = 10;
   logic CLK = 0, RST_N = 0, run = 0, OVER_TEMP = 0, INPUT_UV = 0;
   logic [1:0] ENABLE = 2'h3, PULSE_END = 2'h3, OC_TRIP = 0, NEG_OC = 0, OUT_REGULATED = 0;
   logic [1:0] HS_ON, LS_ON, TRI, OC_FLAG, OC_FAULT, PG;
   logic       SYNC_IN, FORCED_PWM;
   logic [9:0] OC_COUNT;
   int         error_cnt = 0, n_tests = 0, n, i;
   logic       acc;

   always #50 CLK = ~CLK;

   dbp_sync_src src (.CLK(CLK), .run(run), .sync_out(SYNC_IN));
   dbp_top #(.SS_CYCLES(SS)) uut (.CLK(CLK), .RST_N(RST_N), .SYNC_IN(SYNC_IN), .ENABLE(ENABLE),
      .PULSE_END(PULSE_END), .OC_TRIP(OC_TRIP), .NEG_OC(NEG_OC), .OUT_REGULATED(OUT_REGULATED),
      .OVER_TEMP(OVER_TEMP), .INPUT_UV(INPUT_UV), .HS_ON(HS_ON), .LS_ON(LS_ON),
      .SWITCH_NODE_TRISTATE(TRI), .FORCED_PWM(FORCED_PWM), .OC_FLAG(OC_FLAG),
      .OC_FAULT(OC_FAULT), .OUTPUT_GOOD_FLAG(PG), .OC_COUNT(OC_COUNT));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   // Cycles from now to the next rising high-side drive of a channel
   task rise(input int ch, output int c);
      c = 0;
      while (HS_ON[ch] !== 1'b0 && c < 40) begin @(negedge CLK); c++; end
      while (HS_ON[ch] !== 1'b1 && c < 40) begin @(negedge CLK); c++; end
   endtask : rise

   task t_timebase;
      chk(FORCED_PWM, 0);
      rise(0, n); rise(0, n); chk(n, PERIOD_CYC);
      rise(1, n); chk(n, HALF_PERIOD_CYC);
      PULSE_END = 2'h0;
      rise(0, n); @(negedge CLK);
      chk({HS_ON[0], LS_ON[0]}, 2'h2);
      PULSE_END[0] = 1'b1;
      @(negedge CLK); chk({HS_ON[0], LS_ON[0]}, 2'h1);
      acc = 1;
      while (HS_ON[0] !== 1'b1 && n < 40) begin acc &= LS_ON[0]; @(negedge CLK); n++; end
      chk(acc, 1);
      PULSE_END = 2'h3;
   endtask : t_timebase

   task t_overcurrent;
      rise(0, n);
      OC_TRIP[0] = 1'b1;
      #1 chk(HS_ON[0], 0);
      for (i = 0; i < 20 && OC_COUNT[4:0] !== 5'h01; i++) @(negedge CLK);
      chk({OC_FLAG[0], OC_COUNT}, {1'b1, 10'h001});
      acc = 0;
      for (n = 0; n < 200 && OC_FAULT[0] !== 1'b1; n++) begin
         @(negedge CLK);
         if (OC_COUNT[4:0] === 5'h02 && n < 8) acc = 1;
      end
      chk(acc, 1);
      chk(n >= 63 && n <= 65, 1);
      chk(PG, 2'h2);
      OC_TRIP[0] = 1'b0;
      acc = 0;
      for (n = 0; n < 200 && OC_FAULT[0] === 1'b1; n++) begin
         acc |= HS_ON[0] | LS_ON[0]; @(negedge CLK);
      end
      chk(acc, 0);
      chk(n >= 79 && n <= 81, 1);
      chk({OC_FLAG[0], OC_COUNT[4:0]}, 6'h00);
   endtask : t_overcurrent

   task t_flag_drop;
      OC_TRIP[1] = 1'b1;
      for (i = 0; i < 20 && OC_COUNT[9:5] !== 5'h02; i++) @(negedge CLK);
      chk(OC_FLAG[1], 1);
      OC_TRIP[1] = 1'b0;
      repeat (8) @(negedge CLK);
      chk({OC_FLAG[1], OC_COUNT[9:5]}, 6'h00);
   endtask : t_flag_drop

   task t_negative;
      NEG_OC[1] = 1'b1;
      repeat (2) @(negedge CLK);
      NEG_OC[1] = 1'b0;
      repeat (6) @(negedge CLK);
      chk({TRI[1], HS_ON[1], LS_ON[1]}, 3'h4);
      OUT_REGULATED[1] = 1'b1;
      repeat (2) @(negedge CLK);
      OUT_REGULATED[1] = 1'b0;
      chk(TRI[1], 0);
   endtask : t_negative

   task t_faults;
      OVER_TEMP = 1'b1;
      @(negedge CLK);
      chk(PG, 2'h0);
      OVER_TEMP = 1'b0;
      INPUT_UV  = 1'b1;
      @(negedge CLK);
      chk(PG, 2'h0);
      INPUT_UV = 1'b0;
   endtask : t_faults

   task t_sync;
      // Non-blocking, so the source reads the old level at this edge and never races
      run <= 1'b1;
      for (i = 0; i < 20 && FORCED_PWM !== 1'b1; i++) @(negedge CLK);
      chk(FORCED_PWM, 1);
      repeat (12) @(negedge CLK);
      rise(0, n); rise(1, n); chk(n, 3);
      rise(0, n); chk(n, 3);
      rise(0, n); chk(n, 6);
      run <= 1'b0;
   endtask : t_sync

   initial begin
      repeat (2) @(negedge CLK);
      RST_N = 1'b1;
      chk({HS_ON, LS_ON, OC_FLAG, PG}, 8'h03);
      t_timebase;
      t_faults;
      t_overcurrent;
      t_flag_drop;
      t_negative;
      t_sync;
      final_report;
   end

   initial begin
      #200000;
      error_cnt++;
      final_report;
   end
endmodule : tb_dbp_top

/* verilog/dbp_channel.sv */
// One channel: switch phase and overcurrent counting, hiccup and negative tri-state.
// Assumes comparator inputs are synchronous and the cycle start is a one-clock pulse.
`timescale 1ns/1ps
module dbp_channel
   import dbp_pkg::*;
#(
   parameter int unsigned SS_CYCLES = SS_CYC
) (
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic                enable,
   input  wire logic                start,
   input  wire logic                pulse_end,
   input  wire logic                oc_trip,
   input  wire logic                neg_oc,
   input  wire logic                out_regulated,
   input  wire logic                other_fault,
   output logic                     hs_on,
   output logic                     ls_on,
   output logic                     sw_tristate,
   output logic                     oc_flag,
   output logic                     oc_fault,
   output logic                     pg_ok,
   output logic [OC_CNT_W-1:0]      oc_count
);
   dbp_phase_t  phase;
   logic        oc_this;
   logic        oc_seen;
   logic [3:0]  ss_n;
   logic [31:0] ss_cnt;

   // Switch phase
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         phase <= DBP_OFF;
      end else begin
         case (phase)
            DBP_TRI: begin
               if (out_regulated) begin
                  phase <= DBP_OFF;
               end
            end
            default: begin
               if (!enable || oc_fault) begin
                  phase <= DBP_OFF;
               end else if (neg_oc) begin
                  phase <= DBP_TRI;
               end else if (start) begin
                  phase <= DBP_HIGH;
               end else if (phase == DBP_HIGH && (pulse_end || oc_trip)) begin
                  phase <= DBP_LOW;
               end
            end
         endcase
      end
   end

   // A trip in the last clock of a cycle still belongs to that cycle: oc_seen counts it, while the clear of oc_this wins over its set
   assign oc_seen = oc_this | (phase == DBP_HIGH && oc_trip);

   // Overcurrent counter, one per channel
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         oc_this  <= 1'b0;
         oc_count <= OC_CNT_ZERO;
         oc_flag  <= 1'b0;
         oc_fault <= 1'b0;
         ss_n     <= 4'h0;
         ss_cnt   <= 32'h0;
      end else if (oc_fault) begin
         if (ss_cnt == SS_CYCLES - 1) begin
            ss_cnt <= 32'h0;
            if (ss_n == 4'(HICCUP_PERIODS - 1)) begin
               oc_fault <= 1'b0;
               oc_count <= OC_CNT_ZERO;
               oc_flag  <= 1'b0;
               ss_n     <= 4'h0;
            end else begin
               ss_n <= ss_n + 4'h1;
            end
         end else begin
            ss_cnt <= ss_cnt + 32'h1;
         end
      end else begin
         if (phase == DBP_HIGH && oc_trip) begin
            oc_this <= 1'b1;
         end
         if (start) begin
            oc_this <= 1'b0;
            if (oc_seen) begin
               if (oc_count == OC_CNT_ZERO) begin
                  oc_count <= OC_CNT_ONE;
                  oc_flag  <= 1'b1;
               end else begin
                  oc_count <= oc_count + OC_CNT_ONE;
               end
               if (oc_count == OC_CNT_W'(OC_FAULT_LIMIT - 1)) begin
                  oc_fault <= 1'b1;
               end
            end else begin
               oc_count <= OC_CNT_ZERO;
               if (oc_count < OC_CNT_W'(OC_FLAG_LIMIT)) begin
                  oc_flag <= 1'b0;
               end
            end
         end
      end
   end

   always_comb begin
      hs_on       = (phase == DBP_HIGH) && !oc_trip && !oc_fault;
      ls_on       = (phase == DBP_LOW) && !oc_fault;
      sw_tristate = (phase == DBP_TRI);
      pg_ok       = !oc_flag && !oc_fault && !other_fault;
   end

   a_oc_limit_fault: assert property (@(posedge CLK) disable iff (!RST_N)
      (start && oc_seen && !oc_fault && oc_count == OC_CNT_W'(OC_FAULT_LIMIT - 1)) |=> oc_fault)
      else $error("fault not entered at limit");
   a_first_oc_one: assert property (@(posedge CLK) disable iff (!RST_N)
      (start && oc_seen && !oc_fault && oc_count == OC_CNT_ZERO) |=> (oc_count == OC_CNT_ONE && oc_flag))
      else $error("first overcurrent not counted");
   a_hs_oc_off: assert property (@(posedge CLK) disable iff (!RST_N)
      oc_trip |-> !hs_on ##1 ($past(start) || !hs_on))
      else $error("high side on during overcurrent");
   a_fault_both_off: assert property (@(posedge CLK) disable iff (!RST_N)
      oc_fault |-> (!hs_on && !ls_on))
      else $error("switch on during hiccup");
   a_hs_ls_excl: assert property (@(posedge CLK) disable iff (!RST_N)
      !(hs_on && ls_on))
      else $error("shoot-through");
   a_pg_fault: assert property (@(posedge CLK) disable iff (!RST_N)
      (oc_fault || other_fault) |-> !pg_ok)
      else $error("output good high in fault");
   a_low_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (phase == DBP_LOW && !start && enable && !oc_fault && !neg_oc) |=> phase == DBP_LOW)
      else $error("low side dropped early");
   a_neg_tri: assert property (@(posedge CLK) disable iff (!RST_N)
      (neg_oc && enable && !oc_fault && phase != DBP_TRI) |=> sw_tristate)
      else $error("no tri-state on negative limit");
   c_oc_fault: cover property (@(posedge CLK) disable iff (!RST_N) $rose(oc_fault));
   c_hiccup_end: cover property (@(posedge CLK) disable iff (!RST_N) $fell(oc_fault));
   c_tristate: cover property (@(posedge CLK) disable iff (!RST_N) $rose(sw_tristate));
endmodule : dbp_channel

/* verilog/dbp_pkg.sv */
// Package for the dual-channel buck PWM control block.
// Holds timing constants and shared types; no registers, all control is on plain ports.
package dbp_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned FSW_INT_HZ      = 2_500_000;
   // Internal switching period in clock cycles (longest time rounds down)
   localparam int unsigned PERIOD_CYC      = CLK_HZ / FSW_INT_HZ;
   localparam int unsigned HALF_PERIOD_CYC = PERIOD_CYC / 2;
   localparam int unsigned SS_TIME_US      = 1500;
   localparam int unsigned SS_CYC          = SS_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned OC_FAULT_LIMIT  = 17;
   localparam int unsigned OC_FLAG_LIMIT   = 4;
   localparam int unsigned HICCUP_PERIODS  = 8;
   localparam int unsigned OC_CNT_W        = 5;
   localparam logic [OC_CNT_W-1:0] OC_CNT_ONE = 5'h01;
   localparam logic [OC_CNT_W-1:0] OC_CNT_ZERO = 5'h00;

   typedef enum logic [1:0] {
      DBP_OFF,
      DBP_HIGH,
      DBP_LOW,
      DBP_TRI
   } dbp_phase_t;
endpackage : dbp_pkg

/* verilog/dbp_timebase.sv */
// Timebase: internal oscillator or sync-input falling edges, alternating channels.
// Assumes SYNC_IN is synchronous to CLK and pulses last at least one clock.
`timescale 1ns/1ps
module dbp_timebase
   import dbp_pkg::*;
#(
   parameter int unsigned PERIOD = PERIOD_CYC
) (
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RST_N,
   // Timing input
   input  wire logic sync_in,
   // Cycle starts and forced-PWM status
   output logic      start1,
   output logic      start2,
   output logic      forced_pwm
);
   logic [7:0] cnt;
   logic       sync_d;
   logic       next_ch;
   logic       sync_fall;
   logic       sync_seen;
   logic       sync_mode;

   assign sync_fall = sync_d & ~sync_in;
   // The first falling edge already counts as sync timing, so channel one starts on it
   assign sync_mode = sync_seen | sync_fall;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync_d <= 1'b0;
      end else begin
         sync_d <= sync_in;
      end
   end

   // Sync mode is held from the first falling edge until a period ends with no edge and SYNC_IN low; a high level alone forces PWM
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync_seen  <= 1'b0;
         forced_pwm <= 1'b0;
      end else begin
         if (sync_fall) begin
            sync_seen <= 1'b1;
         end else if (cnt == 8'(PERIOD - 1) && !sync_in) begin
            sync_seen <= 1'b0;
         end
         if (cnt == 8'h00 || sync_fall) begin
            forced_pwm <= sync_in | sync_mode;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cnt     <= 8'h00;
         next_ch <= 1'b0;
      end else if (sync_fall) begin
         cnt     <= 8'h00;
         next_ch <= ~next_ch;
      end else if (cnt == 8'(PERIOD - 1)) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   // Internal mode: ch1 at count 0, ch2 half a period later
   assign start1 = sync_mode ? (sync_fall && !next_ch) : (cnt == 8'h00);
   assign start2 = sync_mode ? (sync_fall && next_ch) : (cnt == 8'(PERIOD / 2));
endmodule : dbp_timebase

/* verilog/dbp_top.sv */
// Top: timebase plus two independent channels. All analog comparators arrive as
// synchronous digital levels; the sync source keeps its own frequency and width.
`timescale 1ns/1ps
module dbp_top
   import dbp_pkg::*;
#(
   parameter int unsigned SS_CYCLES = SS_CYC
) (
   // Clock and reset
   input  wire logic                CLK,
   input  wire logic                RST_N,
   // Timing input
   input  wire logic                SYNC_IN,
   // Channel controls
   input  wire logic [1:0]          ENABLE,
   input  wire logic [1:0]          PULSE_END,
   input  wire logic [1:0]          OC_TRIP,
   input  wire logic [1:0]          NEG_OC,
   input  wire logic [1:0]          OUT_REGULATED,
   input  wire logic                OVER_TEMP,
   input  wire logic                INPUT_UV,
   // Switch drives
   output logic [1:0]               HS_ON,
   output logic [1:0]               LS_ON,
   output logic [1:0]               SWITCH_NODE_TRISTATE,
   // Status
   output logic                     FORCED_PWM,
   output logic [1:0]               OC_FLAG,
   output logic [1:0]               OC_FAULT,
   output logic [1:0]               OUTPUT_GOOD_FLAG,
   output logic [2*OC_CNT_W-1:0]    OC_COUNT
);
   logic [1:0] start;

   // The source must keep to the sync range and width; nothing here checks it
   dbp_timebase #(.PERIOD(PERIOD_CYC)) u_tb (
      .CLK        (CLK),
      .RST_N      (RST_N),
      .sync_in    (SYNC_IN),
      .start1     (start[0]),
      .start2     (start[1]),
      .forced_pwm (FORCED_PWM)
   );

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         dbp_channel #(.SS_CYCLES(SS_CYCLES)) u_ch (
            .CLK           (CLK),
            .RST_N         (RST_N),
            .enable        (ENABLE[g]),
            .start         (start[g]),
            .pulse_end     (PULSE_END[g]),
            .oc_trip       (OC_TRIP[g]),
            .neg_oc        (NEG_OC[g]),
            .out_regulated (OUT_REGULATED[g]),
            .other_fault   (OVER_TEMP | INPUT_UV),
            .hs_on         (HS_ON[g]),
            .ls_on         (LS_ON[g]),
            .sw_tristate   (SWITCH_NODE_TRISTATE[g]),
            .oc_flag       (OC_FLAG[g]),
            .oc_fault      (OC_FAULT[g]),
            .pg_ok         (OUTPUT_GOOD_FLAG[g]),
            .oc_count      (OC_COUNT[g*OC_CNT_W +: OC_CNT_W])
         );
      end
   endgenerate

   a_start_apart: assert property (@(posedge CLK) disable iff (!RST_N)
      !(start[0] && start[1]))
      else $error("channels started together");
   a_int_half: assert property (@(posedge CLK) disable iff (!RST_N)
      (start[0] && !SYNC_IN && !FORCED_PWM) |-> ##2 (start[1] || SYNC_IN || FORCED_PWM))
      else $error("channel two not half a period later");
   c_sync: cover property (@(posedge CLK) disable iff (!RST_N) $rose(FORCED_PWM));
endmodule : dbp_top
